// [rtl/debug_halt_pkg.sv]
// Purpose: shared constants for the debug halt-source controller
// Assumes: 32-bit AHB-Lite register window, one word per register
// Notes:   halt-source codes sit in debug status bits 27..24
package debug_halt_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_DEBUG_STATUS  = 8'h00;
    localparam logic [7:0] OFF_SECOND_STATUS = 8'h04;
    localparam logic [7:0] OFF_EXT_STATUS    = 8'h08;
    localparam logic [7:0] OFF_COMMAND       = 8'h0C;
    localparam logic [7:0] OFF_RESUME_PC     = 8'h10;
    localparam logic [7:0] OFF_CONTROL       = 8'h14;
    localparam logic [7:0] OFF_IRQ_STATUS    = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK      = 8'h1C;

    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int HSRC_LSB      = 24;
    localparam int TFH_BIT       = 0;
    localparam int DFR_BIT       = 1;
    localparam int HAR_BIT       = 2;
    localparam int EXT_STOP_BIT  = 0;
    localparam int EXT_HALT_BIT  = 1;
    localparam int EXT_CLK_BIT   = 6;
    localparam int EXT_EN_BIT    = 7;
    localparam int OBTRUSIVE_BIT = 0;
    localparam int IRQ_HALTED    = 0;
    localparam int IRQ_ILLEGAL   = 1;
    localparam int IRQ_TRACE     = 2;
    localparam int IRQ_W         = 3;

    // halt-source codes; resume keeps only bit 27
    localparam logic [3:0] HSRC_NONE       = 4'h0;
    localparam logic [3:0] HSRC_BRK        = 4'h1;
    localparam logic [3:0] HSRC_BACKGROUND = 4'h2;
    localparam logic [3:0] HSRC_PIN_RESET  = 4'h4;
    localparam logic [3:0] HSRC_KEEP       = 4'h8;

    localparam logic [7:0] CMD_HALT   = 8'h01;
    localparam logic [7:0] CMD_RESUME = 8'h02;

    // ------------------------------------------------------------
    // reset values and timing counts
    // ------------------------------------------------------------
    localparam logic [31:0] WORD_RESET     = 32'h0000_0000;
    localparam logic [3:0]  HSRC_RESET     = 4'h0;
    localparam int          SYNC_STAGES    = 2;
    localparam int          PIN_LOW_CLOCKS = 2;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_STOP = 2'b01,
        ST_HALT = 2'b10
    } run_state_type;

endpackage : debug_halt_pkg

// [rtl/debug_pin_conditioner.sv]
// Purpose: synchronise debug pins, detect pin held low after reset
// Assumes: pins idle high through pullups
// Notes:   detect is a one-cycle pulse, at most once per reset
`timescale 1ns/1ns
`default_nettype none
module debug_pin_conditioner
    import debug_halt_pkg::*;
#(
    parameter int LOW_CLOCKS = PIN_LOW_CLOCKS
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic debug_pin_line,
    input  wire logic breakpoint_request_n,
    output logic      brk_sync_n,
    output logic      reset_halt_detect
);

    logic [1:0] pin_ff;
    logic [1:0] brk_ff;
    logic [3:0] win_cnt;
    logic       win_open;

    // ------------------------------------------------------------
    // two-flop synchronisers, reset to the idle level
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pin_ff  <= 2'h3;
            brk_ff  <= 2'h3;
        end else begin
            pin_ff  <= {pin_ff[0], debug_pin_line};
            brk_ff  <= {brk_ff[0], breakpoint_request_n};
        end
    end

    assign brk_sync_n = brk_ff[1];

    // ------------------------------------------------------------
    // window after reset release
    // ------------------------------------------------------------
    // the first stages are settling, so the pin is judged only after
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            win_cnt           <= 4'h0;
            win_open          <= 1'b1;
            reset_halt_detect <= 1'b0;
        end else begin
            reset_halt_detect <= 1'b0;
            if (win_open) begin
                if (win_cnt < 4'(SYNC_STAGES)) begin
                    win_cnt <= win_cnt + 4'h1;
                end else if (pin_ff[1]) begin
                    win_open <= 1'b0;
                end else if (win_cnt == 4'(SYNC_STAGES + LOW_CLOCKS - 1)) begin
                    reset_halt_detect <= 1'b1;
                    win_open          <= 1'b0;
                end else begin
                    win_cnt <= win_cnt + 4'h1;
                end
            end
        end
    end

endmodule : debug_pin_conditioner
`default_nettype wire

// [rtl/debug_halt_control.sv]
// Purpose: halt-source control for the core's background debug unit
// Assumes: AHB-Lite slave, single clock, core gives sample pulses
// Notes:   serial bit protocol lives elsewhere; commands arrive here
//
// Function
// - With debug off or flash secured a halt command is illegal and ignored.
// - A permitted halt command while running pends a halt taken at next sample.
// - A permitted halt command in stop mode enters halt directly.
// - Obtrusive trace mode pends a halt when the trace buffer reaches full.
// - Debug pin low two clocks after reset halts at once, debug and clock set.
// - Resume after reset halt jumps to a written PC, else continues reset.
// - After a secured reset halt resume and non-basic commands are refused.
// - The breakpoint input pends a halt like a halt command, but needs only debug on, not unsecured flash.
// - Extended status always shows separate halted and stopped flags.
// - Bits 27..24 of debug status hold the highest-priority halt source.
// - Reading debug status clears the halt-source field.
// - A trace-full halt sets the trace flag and the breakpoint code.
// - Resume clears bits 26..24 and the trace-full halt flag.
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module debug_halt_control
    import debug_halt_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        debug_pin_line,
    input  wire logic        breakpoint_request_n,
    input  wire logic        flash_secure,
    input  wire logic        instr_sample,
    input  wire logic        core_stop_enter,
    input  wire logic        trace_full,
    output logic             core_halt_req,
    output logic             core_resume,
    output logic             resume_to_pc,
    output logic             resume_reset_seq,
    output logic [31:0]      resume_pc,
    output logic             debug_reset_req,
    output logic             debug_clock_select,
    output logic             irq
);

    logic              bus_take;
    logic              rd_take;
    logic              wr_pend;
    logic [7:0]        wr_addr;
    logic              cmd_wr;
    logic              cmd_halt;
    logic              cmd_resume;
    logic              brk_sync_n;
    logic              brk_prev_n;
    logic              brk_event;
    logic              pin_detect;
    run_state_type     state;
    run_state_type     next_state;
    logic              pend_bg;
    logic              pend_trace;
    logic              halt_entry;
    logic              allowed;
    logic              pc_ok;
    logic              resume_ok;
    logic              illegal;
    logic              rd_clear;
    logic              debug_enable_bit;
    logic              reset_halt;
    logic              pc_written;
    logic              obtrusive;
    logic              halt_after_reset_select;
    logic              trace_full_halt_status;
    logic              trace_entry;
    logic [3:0]        hsrc;
    logic [3:0]        entry_src;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_mask;
    logic [IRQ_W-1:0]  irq_set;
    logic [31:0]       read_value;

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    debug_pin_conditioner #(
        .LOW_CLOCKS (PIN_LOW_CLOCKS)
    ) u_pins (
        .clk_sys              (clk_sys),
        .sys_rst              (sys_rst),
        .debug_pin_line       (debug_pin_line),
        .breakpoint_request_n (breakpoint_request_n),
        .brk_sync_n           (brk_sync_n),
        .reset_halt_detect    (pin_detect)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign bus_take   = hsel & hready & htrans[1];
    assign rd_take    = bus_take & ~hwrite;
    assign cmd_wr     = wr_pend & hit(wr_addr, OFF_COMMAND);
    assign cmd_halt   = cmd_wr & (hwdata[7:0] == CMD_HALT);
    assign cmd_resume = cmd_wr & (hwdata[7:0] == CMD_RESUME);
    assign rd_clear   = rd_take & hit(haddr[7:0], OFF_DEBUG_STATUS);

    // ------------------------------------------------------------
    // command qualification
    // ------------------------------------------------------------
    assign allowed    = debug_enable_bit & ~flash_secure;
    assign brk_event  = brk_prev_n & ~brk_sync_n & debug_enable_bit;
    // only basic commands after a secured reset halt
    assign pc_ok      = (state == ST_HALT) & ~(reset_halt & flash_secure);
    assign resume_ok  = cmd_resume & pc_ok;
    assign illegal    = (cmd_halt & ~allowed)
                      | (cmd_resume & ~resume_ok)
                      | (wr_pend & hit(wr_addr, OFF_RESUME_PC) & ~pc_ok);
    assign halt_entry = (state != ST_HALT) & (next_state == ST_HALT);
    assign trace_entry = halt_entry & (state == ST_RUN) & ~pin_detect
                       & ~pend_bg & pend_trace;

    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (pin_detect) begin
                    next_state = ST_HALT;
                end else if (instr_sample & (pend_bg | pend_trace)) begin
                    next_state = ST_HALT;
                end else if (core_stop_enter) begin
                    next_state = ST_STOP;
                end
            end
            ST_STOP: begin
                if ((cmd_halt & allowed) | brk_event) begin
                    next_state = ST_HALT;
                end
            end
            ST_HALT: begin
                if (resume_ok) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    // highest-priority source wins the field
    always_comb begin
        if (pin_detect) begin
            entry_src = HSRC_PIN_RESET;
        end else if ((state == ST_STOP) | pend_bg) begin
            entry_src = HSRC_BACKGROUND;
        end else begin
            entry_src = HSRC_BRK;
        end
    end

    // ------------------------------------------------------------
    // run state and pending halts
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state         <= ST_RUN;
            core_halt_req <= 1'b0;
            brk_prev_n    <= 1'b1;
        end else begin
            state         <= next_state;
            core_halt_req <= (next_state == ST_HALT);
            brk_prev_n    <= brk_sync_n;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pend_bg    <= 1'b0;
            pend_trace <= 1'b0;
        end else if (halt_entry) begin
            pend_bg    <= 1'b0;
            pend_trace <= 1'b0;
        end else if (state == ST_RUN) begin
            if ((cmd_halt & allowed) | brk_event) begin
                pend_bg <= 1'b1;
            end
            if (obtrusive & trace_full) begin
                pend_trace <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // debug configuration and resume target
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            debug_enable_bit        <= 1'b0;
            debug_clock_select      <= 1'b0;
            obtrusive               <= 1'b0;
            halt_after_reset_select <= 1'b0;
        end else begin
            if (pin_detect) begin
                debug_enable_bit   <= 1'b1;
                debug_clock_select <= 1'b1;
            end else if (wr_pend & hit(wr_addr, OFF_EXT_STATUS)) begin
                debug_enable_bit   <= hwdata[EXT_EN_BIT];
                debug_clock_select <= hwdata[EXT_CLK_BIT];
            end
            if (wr_pend & hit(wr_addr, OFF_CONTROL)) begin
                obtrusive <= hwdata[OBTRUSIVE_BIT];
            end
            if (wr_pend & hit(wr_addr, OFF_SECOND_STATUS)) begin
                halt_after_reset_select <= hwdata[HAR_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reset_halt <= 1'b0;
            pc_written <= 1'b0;
            resume_pc  <= WORD_RESET;
        end else begin
            if (pin_detect) begin
                reset_halt <= 1'b1;
            end else if (resume_ok) begin
                reset_halt <= 1'b0;
            end
            if (resume_ok) begin
                pc_written <= 1'b0;
            end else if (wr_pend & hit(wr_addr, OFF_RESUME_PC) & pc_ok) begin
                resume_pc  <= hwdata;
                pc_written <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            core_resume      <= 1'b0;
            resume_to_pc     <= 1'b0;
            resume_reset_seq <= 1'b0;
            debug_reset_req  <= 1'b0;
        end else begin
            core_resume      <= resume_ok;
            resume_to_pc     <= resume_ok & reset_halt & pc_written;
            resume_reset_seq <= resume_ok & reset_halt & ~pc_written;
            debug_reset_req  <= wr_pend & hit(wr_addr, OFF_SECOND_STATUS)
                              & hwdata[DFR_BIT];
        end
    end

    // ------------------------------------------------------------
    // halt-source field and trace flag
    // ------------------------------------------------------------
    // a new halt beats a same-cycle read or resume clear
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hsrc                   <= HSRC_RESET;
            trace_full_halt_status <= 1'b0;
        end else begin
            if (halt_entry) begin
                hsrc <= entry_src;
            end else if (rd_clear) begin
                hsrc <= HSRC_NONE;
            end else if (resume_ok) begin
                hsrc <= hsrc & HSRC_KEEP;
            end
            if (trace_entry) begin
                trace_full_halt_status <= 1'b1;
            end else if (resume_ok) begin
                trace_full_halt_status <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    assign irq_set = {trace_entry, illegal, halt_entry};

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq_stat <= '0;
            irq_mask <= '0;
            irq      <= 1'b0;
        end else begin
            if (wr_pend & hit(wr_addr, OFF_IRQ_STATUS)) begin
                irq_stat <= (irq_stat & ~hwdata[IRQ_W-1:0]) | irq_set;
            end else begin
                irq_stat <= irq_stat | irq_set;
            end
            if (wr_pend & hit(wr_addr, OFF_IRQ_MASK)) begin
                irq_mask <= hwdata[IRQ_W-1:0];
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------
    always_comb begin
        read_value = WORD_RESET;
        case (haddr[7:0])
            OFF_DEBUG_STATUS: read_value[HSRC_LSB +: 4] = hsrc;
            OFF_SECOND_STATUS: begin
                read_value[TFH_BIT] = trace_full_halt_status;
                read_value[HAR_BIT] = halt_after_reset_select;
            end
            OFF_EXT_STATUS: begin
                read_value[EXT_EN_BIT]   = debug_enable_bit;
                read_value[EXT_CLK_BIT]  = debug_clock_select;
                read_value[EXT_HALT_BIT] = (state == ST_HALT);
                read_value[EXT_STOP_BIT] = (state == ST_STOP);
            end
            OFF_RESUME_PC: read_value = resume_pc;
            OFF_CONTROL: read_value[OBTRUSIVE_BIT] = obtrusive;
            OFF_IRQ_STATUS: read_value[IRQ_W-1:0] = irq_stat;
            OFF_IRQ_MASK: read_value[IRQ_W-1:0] = irq_mask;
            default: read_value = WORD_RESET;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            hrdata    <= WORD_RESET;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend   <= bus_take & hwrite;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (bus_take) begin
                wr_addr <= haddr[7:0];
            end
            if (rd_take) begin
                hrdata <= read_value;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_reset_resume;
        state == ST_HALT && cmd_resume && reset_halt && !flash_secure;
    endsequence

    sequence s_pc_taken;
        resume_to_pc && !resume_reset_seq ##1 !resume_to_pc;
    endsequence

    AST_ILLEGAL_IGNORED: assert property (
        state != ST_HALT && cmd_halt && !allowed && !brk_event && !pend_bg
        && !pend_trace && !pin_detect
        |=> state != ST_HALT && !pend_bg && irq_stat[IRQ_ILLEGAL])
        else $error("refused halt changed state");
    AST_PEND_ON_CMD: assert property (
        state == ST_RUN && cmd_halt && allowed && !instr_sample
        && !pin_detect |=> pend_bg ##0 !core_halt_req)
        else $error("halt command did not pend");
    AST_HALT_AT_SAMPLE: assert property (
        state == ST_RUN && instr_sample && (pend_bg || pend_trace)
        |=> core_halt_req && state == ST_HALT)
        else $error("pending halt not taken at sample");
    AST_STOP_EXIT: assert property (
        state == ST_STOP && cmd_halt && allowed
        |=> state == ST_HALT && hsrc == HSRC_BACKGROUND)
        else $error("stop mode not left on halt command");
    AST_TRACE_PEND: assert property (
        state == ST_RUN && obtrusive && trace_full && !halt_entry
        |=> pend_trace)
        else $error("trace full did not pend");
    AST_RESET_HALT: assert property (
        pin_detect |=> state == ST_HALT && debug_enable_bit
        && debug_clock_select && hsrc == HSRC_PIN_RESET)
        else $error("reset-time halt missing");
    AST_RESUME_PC: assert property (
        s_reset_resume and pc_written |=> s_pc_taken)
        else $error("resume did not jump to pc");
    AST_SECURE_REFUSE: assert property (
        state == ST_HALT && cmd_resume && reset_halt && flash_secure
        |=> state == ST_HALT && !core_resume && irq_stat[IRQ_ILLEGAL])
        else $error("secured resume not refused");
    AST_BREAKPOINT_REQUEST_PEND: assert property (
        state == ST_RUN && brk_event && !halt_entry |=> pend_bg)
        else $error("breakpoint did not pend");
    AST_FLAGS_APART: assert property (
        rd_take && haddr[7:0] == OFF_EXT_STATUS
        |=> {hrdata[EXT_HALT_BIT], hrdata[EXT_STOP_BIT]}
        == {$past(state == ST_HALT), $past(state == ST_STOP)})
        else $error("halted and stopped together");
    AST_SRC_READ_CLEAR: assert property (
        rd_clear && !halt_entry |=> hsrc == HSRC_NONE)
        else $error("status read did not clear source");
    AST_TRACE_FLAG: assert property (
        trace_entry |=> trace_full_halt_status && hsrc == HSRC_BRK)
        else $error("trace halt flags missing");
    AST_RESUME_CLEAR: assert property (
        resume_ok |=> hsrc[2:0] == 3'h0 && !trace_full_halt_status)
        else $error("resume left source bits");
    AST_PEND_CLEARED: assert property (
        state == ST_HALT |-> !pend_bg && !pend_trace)
        else $error("pending halt survived entry");

endmodule : debug_halt_control
`default_nettype wire

// [bench/core_sample_model.sv]
// Purpose: core model giving one sample point every fourth cycle
// Assumes: sample points stop while the core is halted
// Notes:   stop mode is left to the bench, which drives core_stop_enter
`timescale 1ns/1ns
`default_nettype none
module core_sample_model (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic core_halt_req,
    output logic      instr_sample
);
    logic [1:0] cnt;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            cnt <= 2'h0;
        else
            cnt <= cnt + 2'h1;
    end
    // a halted core executes nothing, so it offers no sample point
    assign instr_sample = (cnt == 2'h3) && !core_halt_req;
endmodule : core_sample_model
`default_nettype wire

// [bench/debug_halt_source_control_tb.sv]
// Purpose: self-checking bench for the halt-source controller
// Assumes: zero-wait AHB-Lite slave, hready tied to hreadyout
// Notes:   the debug pin is held low through the first reset
`timescale 1ns/1ns
`default_nettype none
module debug_halt_source_control_tb
    import debug_halt_pkg::*;
;
    logic        clk_sys = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, resume_pc, q;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        debug_pin_line = 1'b0, breakpoint_request_n = 1'b1;
    logic        flash_secure = 1'b0, core_stop_enter = 1'b0, trace_full = 1'b0;
    logic        hreadyout, hresp, instr_sample, core_halt_req, core_resume;
    logic        resume_to_pc, resume_reset_seq, debug_reset_req;
    logic        debug_clock_select, irq;
    int          bad_count = 0, compares = 0, cyc = 0;

    always #5 clk_sys = ~clk_sys;
    core_sample_model core (.clk_sys, .sys_rst, .core_halt_req, .instr_sample);
    debug_halt_control DUT (.clk_sys, .sys_rst, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .debug_pin_line, .breakpoint_request_n, .flash_secure,
        .instr_sample, .core_stop_enter, .trace_full, .core_halt_req,
        .core_resume, .resume_to_pc, .resume_reset_seq, .resume_pc,
        .debug_reset_req, .debug_clock_select, .irq);

    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer
    task rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
        chk({30'h0, hreadyout, hresp}, 32'h2);
    endtask : rd
    task wait_halt(input logic e);
        repeat (40) if (core_halt_req !== e) @(negedge clk_sys);
        @(posedge clk_sys);
        chk({31'h0, core_halt_req}, {31'h0, e});
    endtask : wait_halt
    task resume_chk;
        xfer(1'b1, OFF_COMMAND, {24'h0, CMD_RESUME});
        @(negedge clk_sys);
        chk({31'h0, core_resume}, 32'h1);
        repeat (8) @(negedge clk_sys);
        chk({31'h0, core_halt_req}, 32'h0);
        @(posedge clk_sys);
    endtask : resume_chk
    task reboot(input logic pin, input logic sec);
        debug_pin_line <= pin; flash_secure <= sec; sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
    endtask : reboot

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task reset_halt;
        wait_halt(1'b1);
        chk({31'h0, debug_clock_select}, 32'h1);
        rd(OFF_EXT_STATUS, 32'hC2);
        rd(OFF_DEBUG_STATUS, {4'h0, HSRC_PIN_RESET, 24'h0});
        rd(OFF_DEBUG_STATUS, 32'h0);
        debug_pin_line <= 1'b1;
        xfer(1'b1, OFF_RESUME_PC, 32'h0000_1234);
        xfer(1'b1, OFF_COMMAND, {24'h0, CMD_RESUME});
        @(negedge clk_sys);
        chk({30'h0, resume_to_pc, resume_reset_seq}, 32'h2);
        chk(resume_pc, 32'h0000_1234);
        @(posedge clk_sys);
    endtask : reset_halt
    task secure_halt;
        reboot(1'b0, 1'b1);
        wait_halt(1'b1);
        xfer(1'b1, OFF_COMMAND, {24'h0, CMD_RESUME});
        rd(OFF_IRQ_STATUS, 32'h3);
        chk({31'h0, core_halt_req}, 32'h1);
        xfer(1'b1, OFF_SECOND_STATUS, 32'h2);
        @(posedge clk_sys);
        chk({31'h0, debug_reset_req}, 32'h1);
        reboot(1'b0, 1'b0);
        wait_halt(1'b1);
        xfer(1'b1, OFF_COMMAND, {24'h0, CMD_RESUME});
        @(posedge clk_sys);
        chk({30'h0, resume_to_pc, resume_reset_seq}, 32'h1);
        reboot(1'b1, 1'b0);
        repeat (8) @(posedge clk_sys);
        rd(OFF_EXT_STATUS, 32'h0);
    endtask : secure_halt
    task illegal_irq;
        xfer(1'b1, OFF_COMMAND, {24'h0, CMD_HALT});
        rd(OFF_IRQ_STATUS, 32'h2);
        xfer(1'b1, OFF_IRQ_MASK, 32'h2);
        rd(OFF_EXT_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b1, OFF_IRQ_STATUS, 32'h2);
        rd(OFF_IRQ_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask : illegal_irq
    task halt_cmd;
        xfer(1'b1, OFF_EXT_STATUS, 32'h80);
        xfer(1'b1, OFF_COMMAND, {24'h0, CMD_HALT});
        wait_halt(1'b1);
        rd(OFF_DEBUG_STATUS, {4'h0, HSRC_BACKGROUND, 24'h0});
        resume_chk;
    endtask : halt_cmd
    task trace_halt;
        xfer(1'b1, OFF_CONTROL, 32'h1);
        trace_full <= 1'b1;
        wait_halt(1'b1);
        trace_full <= 1'b0;
        rd(OFF_SECOND_STATUS, 32'h1);
        rd(OFF_DEBUG_STATUS, {4'h0, HSRC_BRK, 24'h0});
        resume_chk;
        rd(OFF_SECOND_STATUS, 32'h0);
    endtask : trace_halt
    task pin_stop;
        breakpoint_request_n <= 1'b0;
        wait_halt(1'b1);
        breakpoint_request_n <= 1'b1;
        rd(OFF_DEBUG_STATUS, {4'h0, HSRC_BACKGROUND, 24'h0});
        resume_chk;
        core_stop_enter <= 1'b1;
        @(posedge clk_sys);
        core_stop_enter <= 1'b0;
        rd(OFF_EXT_STATUS, 32'h81);
        xfer(1'b1, OFF_COMMAND, {24'h0, CMD_HALT});
        wait_halt(1'b1);
        rd(OFF_EXT_STATUS, 32'h82);
        resume_chk;
    endtask : pin_stop
    task conclude;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            conclude;
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        reset_halt;
        secure_halt;
        illegal_irq;
        halt_cmd;
        trace_halt;
        pin_stop;
        conclude;
    end
endmodule : debug_halt_source_control_tb
`default_nettype wire
